// [hdl/late_write_burst_sram_port.sv]
// Late-write pipelined burst static memory port with APB status access
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module late_write_burst_sram_port (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Command pins
  input wire logic [18:0] addr,
  input wire logic advance_or_load,
  input wire logic read_write_sel,
  input wire logic chip_select_a_n,
  input wire logic chip_select_b,
  input wire logic chip_select_c_n,
  input wire logic [3:0] byte_lane_write_n,
  input wire logic clock_hold_n,
  input wire logic burst_order_select_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  // Data pins, parity lanes in bits 35:32
  input wire logic [35:0] dq_in,
  output logic [35:0] dq_out,
  output logic dq_oe,
  // APB register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // -----------------------------------------------------------------------
  // Command decode
  // -----------------------------------------------------------------------
  late_write_burst_sram_port_pkg::cmd_t s1_q;  // Command one edge old
  late_write_burst_sram_port_pkg::cmd_t s2_q;  // Command two edges old
  late_write_burst_sram_port_pkg::cmd_t s1_d;  // Next first stage
  late_write_burst_sram_port_pkg::burst_t burst_q;  // Burst context
  late_write_burst_sram_port_pkg::burst_t burst_d;
  logic [18:0] base_q;        // Burst start address
  logic [18:0] base_d;
  logic [1:0] cnt_q;          // Burst step count
  logic [1:0] cnt_d;
  logic [35:0] dq_out_q;      // Registered read data
  logic out_drv_q;            // Read data due on the pins
  logic [31:0] cfg_q;         // Configuration register
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // Edge counts only when not held and not asleep
  wire en = !clock_hold_n && !sleep_request;
  // Load when advance_or_load is low, advance otherwise
  wire load = !advance_or_load;
  // All three chip selects must agree to select
  wire sel_ok = !chip_select_a_n && chip_select_b && !chip_select_c_n;
  wire take_rd = load && sel_ok && read_write_sel;
  wire take_wr = load && sel_ok && !read_write_sel;
  wire load_desel = load && !sel_ok;
  wire in_burst = burst_q != late_write_burst_sram_port_pkg::BURST_IDLE;
  // Next step of the two burst address bits
  wire [1:0] cnt_inc = cnt_q + 2'h1;
  wire [1:0] lin_low = base_q[1:0] + cnt_inc;
  wire [1:0] ilv_low = base_q[1:0] ^ cnt_inc;
  wire [1:0] nxt_low = burst_order_select_n ? ilv_low : lin_low;
  wire parity_en = cfg_q[late_write_burst_sram_port_pkg::CFG_PARITY_BIT];

  // Next first stage and burst context from the command pins
  always_comb begin
    s1_d = late_write_burst_sram_port_pkg::CMD_RESET;
    burst_d = burst_q;
    base_d = base_q;
    cnt_d = cnt_q;
    if (load) begin
      // New operation, or deselect when any select is off
      s1_d.valid = sel_ok;
      s1_d.write = !read_write_sel;
      s1_d.addr = addr;
      s1_d.be_n = byte_lane_write_n;
      base_d = addr;
      cnt_d = 2'h0;
      if (!sel_ok) begin
        burst_d = late_write_burst_sram_port_pkg::BURST_IDLE;
      end else if (read_write_sel) begin
        burst_d = late_write_burst_sram_port_pkg::BURST_READ;
      end else begin
        burst_d = late_write_burst_sram_port_pkg::BURST_WRITE;
      end
    end else if (in_burst) begin
      // Continue burst: external address and direction ignored
      s1_d.valid = 1'b1;
      s1_d.write = burst_q == late_write_burst_sram_port_pkg::BURST_WRITE;
      s1_d.addr = {base_q[18:2], nxt_low};
      s1_d.be_n = byte_lane_write_n;
      cnt_d = cnt_inc;
    end
  end

  // -----------------------------------------------------------------------
  // Pipeline
  // -----------------------------------------------------------------------
  // Two stages so both read and write data sit two edges behind the command
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= late_write_burst_sram_port_pkg::CMD_RESET;
      s2_q <= late_write_burst_sram_port_pkg::CMD_RESET;
    end else if (en) begin
      s1_q <= s1_d;
      s2_q <= s1_q;
    end
  end

  // Burst context, advanced only on enabled edges
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      burst_q <= late_write_burst_sram_port_pkg::BURST_IDLE;
      base_q <= '0;
      cnt_q <= 2'h0;
    end else if (en) begin
      burst_q <= burst_d;
      base_q <= base_d;
      cnt_q <= cnt_d;
    end
  end

  // -----------------------------------------------------------------------
  // Memory array, one bank per byte lane
  // -----------------------------------------------------------------------
  // Write store fires at the edge that takes the late data
  wire store_now = en && s2_q.valid && s2_q.write;
  wire [35:0] rd_word;   // Read word with pending write merged in

  for (genvar i = 0; i < late_write_burst_sram_port_pkg::LANES; i++)
  begin : g_lane
    // Lane storage, no reset: contents survive sleep and hold
    logic [8:0] lane_mem [0:late_write_burst_sram_port_pkg::WORDS-1];
    wire [8:0] wr_lane;  // Incoming lane from the pins
    wire [8:0] rd_lane;  // Lane returned to a read
    wire fwd;            // Same-address write being stored now

    assign wr_lane = {dq_in[late_write_burst_sram_port_pkg::PAR_BASE + i]
      & parity_en, dq_in[8*i +: 8]};
    assign fwd = s2_q.valid && s2_q.write && !s2_q.be_n[i] &&
      (s2_q.addr == s1_q.addr);
    assign rd_lane = fwd ? wr_lane : lane_mem[s1_q.addr];
    assign rd_word[8*i +: 8] = rd_lane[7:0];
    assign rd_word[late_write_burst_sram_port_pkg::PAR_BASE + i] =
      rd_lane[8] & parity_en;

    // Only lanes with their enable low are changed
    always_ff @(posedge mclk) begin
      if (store_now && !s2_q.be_n[i]) begin
        lane_mem[s2_q.addr] <= wr_lane;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Read data path
  // -----------------------------------------------------------------------
  // Read data launched at the first edge after its command
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dq_out_q <= '0;
      out_drv_q <= 1'b0;
    end else if (en) begin
      out_drv_q <= s1_q.valid && !s1_q.write;
      if (s1_q.valid && !s1_q.write) begin
        dq_out_q <= rd_word;
      end
    end
  end

  assign dq_out = dq_out_q;
  // Output enable and sleep act without the clock
  assign dq_oe = out_drv_q && !output_enable_n && !sleep_request;

  // -----------------------------------------------------------------------
  // APB register slave
  // -----------------------------------------------------------------------
  wire apb_acc = psel && penable && !pready_q;
  wire hit_cfg = paddr == late_write_burst_sram_port_pkg::CFG_OFF;
  wire hit_st = paddr == late_write_burst_sram_port_pkg::STATUS_OFF;
  wire [31:0] status_word = {26'h0000000, burst_q, out_drv_q, s2_q.valid,
    s1_q.valid, sleep_request};
  wire [31:0] rd_mux = hit_cfg ? cfg_q : (hit_st ? status_word : 32'h0);

  // One wait state, then a single-cycle ready
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= apb_acc;
      pslverr_q <= apb_acc && !hit_cfg && !hit_st;
      prdata_q <= (apb_acc && !pwrite) ? rd_mux : 32'h0;
    end
  end

  // Configuration write, taken at the ready edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= late_write_burst_sram_port_pkg::CFG_RESET;
    end else if (psel && penable && pready_q && pwrite && hit_cfg) begin
      cfg_q <= {31'h0, pwdata[late_write_burst_sram_port_pkg::CFG_PARITY_BIT]};
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence rd_taken_s;
    en && take_rd ##1 en;
  endsequence

  sequence wr_taken_s;
    en && take_wr ##1 en ##1 en;
  endsequence

  read_latency_a: assert property (rd_taken_s |=> out_drv_q)
    else $error("read data not driven two edges after command");

  write_capture_a: assert property (wr_taken_s |-> store_now)
    else $error("write data not stored two edges after command");

  hold_freeze_a: assert property (!en |=> $stable(s1_q) && $stable(s2_q)
    && $stable(dq_out_q) && $stable(burst_q))
    else $error("state moved during clock hold or sleep");

  deselect_float_a: assert property (en && load_desel ##1 en
    |=> !out_drv_q)
    else $error("outputs driven after deselect");

  pending_done_a: assert property (rd_taken_s ##0 load_desel
    |=> out_drv_q)
    else $error("read in flight lost by following deselect");

  oe_gate_a: assert property (output_enable_n || sleep_request
    |-> !dq_oe)
    else $error("pins driven with output enable off or asleep");

  load_addr_a: assert property (en && take_rd ##0 !take_wr
    |=> s1_q.valid && s1_q.addr == $past(addr) && !s1_q.write)
    else $error("load did not take external address");

  be_sample_a: assert property (en && (take_wr ||
    (!load && burst_q == late_write_burst_sram_port_pkg::BURST_WRITE))
    |=> s1_q.be_n == $past(byte_lane_write_n))
    else $error("byte enables not sampled with write");

  burst_step_a: assert property (en && !load && in_burst |=>
    s1_q.valid && s1_q.addr[18:2] == $past(base_q[18:2]) &&
    s1_q.addr[1:0] == ($past(burst_order_select_n) ?
    ($past(base_q[1:0]) ^ $past(cnt_inc)) :
    ($past(base_q[1:0]) + $past(cnt_inc))))
    else $error("burst address step wrong");

  forward_word_a: assert property (en && s1_q.valid && !s1_q.write &&
    s2_q.valid && s2_q.write && s2_q.be_n == 4'h0 &&
    s1_q.addr == s2_q.addr |=> dq_out_q[31:0] == $past(dq_in[31:0]))
    else $error("read missed pending write data");

endmodule

// [hdl/late_write_burst_sram_port_pkg.sv]
// Shared constants and types for the late-write burst static memory port
package late_write_burst_sram_port_pkg;

  // ---------------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------------
  localparam int WORDS = 524288;        // Words held in the array
  localparam int ADDR_W = 19;           // Word address width
  localparam int LANES = 4;             // Byte lanes per word
  localparam int BYTE_W = 8;            // Data bits per lane
  localparam int LANE_W = 9;            // Data bits plus parity bit per lane
  localparam int DATA_W = 36;           // Full pin width, parity included
  localparam int PAR_BASE = 32;         // Position of lane 0 parity bit
  localparam int BURST_W = 2;           // Address bits walked by a burst

  // ---------------------------------------------------------------------
  // Software register map (APB, byte addresses)
  // ---------------------------------------------------------------------
  localparam int APB_ADDR_W = 8;                 // Decoded address bits
  localparam logic [7:0] CFG_OFF = 8'h00;        // Configuration register
  localparam logic [7:0] STATUS_OFF = 8'h04;     // Status register
  localparam logic [31:0] CFG_RESET = 32'h00000001; // Parity lanes on
  localparam int CFG_PARITY_BIT = 0;             // Parity lanes enable
  localparam int ST_SLEEP_BIT = 0;               // Sleep request seen
  localparam int ST_STAGE1_BIT = 1;              // First stage occupied
  localparam int ST_STAGE2_BIT = 2;              // Second stage occupied
  localparam int ST_DRIVE_BIT = 3;               // Read data on the pins
  localparam int ST_BURST_LSB = 4;               // Burst state field

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  // Burst context left by the last load
  typedef enum logic [1:0] {
    BURST_IDLE,
    BURST_READ,
    BURST_WRITE
  } burst_t;

  // One operation moving down the two-stage pipeline
  typedef struct packed {
    logic valid;                  // Operation present
    logic write;                  // Write when set, read otherwise
    logic [ADDR_W-1:0] addr;      // Word address
    logic [LANES-1:0] be_n;       // Active-low byte lane enables
  } cmd_t;

  localparam cmd_t CMD_RESET = '0;  // Empty pipeline slot

endpackage

// [tb/late_write_master_model.sv]
// Bus master data side: presents late write data to the memory port
`timescale 1ns/1ps
module late_write_master_model (
  // Clock and stall pins
  input wire logic mclk,
  input wire logic clock_hold_n,
  input wire logic sleep_request,
  // Write data handed over with each write command
  input wire logic push,
  input wire logic [35:0] word,
  // Data pins into the port
  output logic [35:0] dq_in
);
  logic [36:0] s1_q = '0; // Word one enabled edge old
  logic [36:0] s2_q = '0; // Word due at the next enabled edge
  logic [35:0] junk_q = 36'h5a5a5a5a5; // Filler, flips each cycle
  // Only enabled edges move late data along; held edges do not count
  always @(posedge mclk) begin
    junk_q <= ~junk_q;
    if (!clock_hold_n && !sleep_request) begin
      s1_q <= {push, word};
      s2_q <= s1_q;
    end
  end
  // Outside its slot the bus shows a changing pattern, never stale data
  assign dq_in = s2_q[36] ? s2_q[35:0] : junk_q;
endmodule

// [tb/tb_late_write_burst_sram_port.sv]
// Self-checking bench for the late-write burst memory port
`timescale 1ns/1ps
module tb_late_write_burst_sram_port;
  // --------------------------------------------------------------
  // Pins, model link and bench state
  // --------------------------------------------------------------
  localparam logic [2:0] SEL = 3'b010; // All three selects on
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [18:0] addr = '0;
  logic advance_or_load = 1'b0;
  logic read_write_sel = 1'b1;
  logic chip_select_a_n = 1'b1;
  logic chip_select_b = 1'b0;
  logic chip_select_c_n = 1'b1;
  logic [3:0] byte_lane_write_n = 4'hf;
  logic clock_hold_n = 1'b0;
  logic burst_order_select_n = 1'b1;
  logic output_enable_n = 1'b0;
  logic sleep_request = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic push = 1'b0; // Hands write data to the master model
  logic [35:0] word = '0;
  logic [35:0] dq_in;
  logic [35:0] dq_out;
  logic dq_oe;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic par_on = 1'b1; // Parity lanes kept
  logic [35:0] exp_mem [int]; // Expected array words
  int err_count = 0;
  int comparisons = 0;
  // Free-running clock
  always #2 mclk = ~mclk;
  late_write_burst_sram_port dut_u (.mclk, .rst_n, .addr, .advance_or_load,
    .read_write_sel, .chip_select_a_n, .chip_select_b, .chip_select_c_n,
    .byte_lane_write_n, .clock_hold_n, .burst_order_select_n,
    .output_enable_n, .sleep_request, .dq_in, .dq_out, .dq_oe, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  late_write_master_model master_u (.mclk, .clock_hold_n, .sleep_request,
    .push, .word, .dq_in);
  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One command edge; advance cycles put junk on the ignored pins
  task automatic cmd(input logic burst, input logic rw, input logic [18:0] a,
      input logic [3:0] be, input logic [2:0] cs, input logic [35:0] d);
    @(posedge mclk);
    advance_or_load <= burst;
    read_write_sel <= rw ^ burst;
    addr <= burst ? ~a : a;
    byte_lane_write_n <= be;
    {chip_select_a_n, chip_select_b, chip_select_c_n} <= burst ? ~cs : cs;
    push <= !rw && (burst || cs == SEL);
    word <= d;
    if (!rw && (burst || cs == SEL))
      for (int i = 0; i < 4; i++)
        if (!be[i]) begin
          exp_mem[a][8*i +: 8] = d[8*i +: 8];
          exp_mem[a][32+i] = par_on & d[32+i];
        end
  endtask
  task automatic wr(input logic [18:0] a, input logic [3:0] be,
      input logic [35:0] d);
    cmd(1'b0, 1'b0, a, be, SEL, d);
  endtask
  task automatic rd(input logic [18:0] a);
    cmd(1'b0, 1'b1, a, 4'hf, SEL, '0);
  endtask
  task automatic idle();
    cmd(1'b0, 1'b1, '0, 4'hf, 3'b110, '0);
  endtask
  // Read, then judge the pins two edges later
  task automatic rd_chk(input logic [18:0] a);
    rd(a);
    idle();
    idle();
    #1 chk(dq_out, exp_mem[a]);
    chk(dq_oe, 1'b1);
  endtask
  // Address of burst step s from start offset 1
  function automatic logic [18:0] baddr(input logic ln, input int s);
    return {17'h8, ln ? 2'(1 ^ s) : 2'(1 + s)};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk(pready, 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_basic();
    wr(19'h7ffff, 4'h0, 36'h912345678);
    wr(19'h00000, 4'h0, 36'h6cafef00d);
    wr(19'h00000, 4'hf, 36'h0deadbeef);
    wr(19'h00000, 4'b1010, 36'h5aaaa5555);
    rd_chk(19'h7ffff);
    rd_chk(19'h00000);
    $display("basic writes done");
  endtask
  task automatic t_fwd();
    wr(19'h10, 4'h0, 36'h311112222);
    rd(19'h10);
    wr(19'h11, 4'h0, 36'hc33334444);
    rd(19'h11);
    #1 chk(dq_out, exp_mem[19'h10]);
    idle();
    idle();
    #1 chk(dq_out, exp_mem[19'h11]);
    $display("mixed traffic done");
  endtask
  task automatic t_desel();
    logic [2:0] off [3] = '{3'b110, 3'b000, 3'b011};
    for (int i = 0; i < 3; i++) begin
      rd(19'h10);
      cmd(1'b0, 1'b1, 19'h10, 4'hf, off[i], '0);
      idle();
      #1 chk(dq_oe, 1'b1);
      idle();
      #1 chk(dq_oe, 1'b0);
    end
    $display("deselect done");
  endtask
  task automatic t_burst(input logic ln);
    @(posedge mclk);
    burst_order_select_n <= ln;
    for (int s = 0; s < 4; s++)
      cmd(s != 0, 1'b0, baddr(ln, s), 4'h0, SEL, {27'h5, ln, 8'(s)});
    for (int s = 0; s < 6; s++) begin
      if (s < 4)
        cmd(s != 0, 1'b1, baddr(ln, s), 4'hf, SEL, '0);
      else
        idle();
      #1;
      if (s >= 2)
        chk(dq_out, exp_mem[baddr(ln, s - 2)]);
    end
    rd_chk(baddr(ln, 2));
    $display("burst order %0d done", ln);
  endtask
  task automatic t_hold();
    rd(19'h10);
    @(posedge mclk);
    clock_hold_n <= 1'b1;
    repeat (3) begin
      @(posedge mclk);
      #1 chk(dq_oe, 1'b0);
    end
    @(posedge mclk);
    clock_hold_n <= 1'b0;
    @(posedge mclk);
    #1 chk(dq_out, exp_mem[19'h10]);
    idle();
    idle();
    $display("clock hold done");
  endtask
  task automatic t_oe_sleep();
    logic [35:0] keep;
    keep = exp_mem[19'h10];
    repeat (3) rd(19'h10);
    output_enable_n <= 1'b1;
    #1 chk(dq_oe, 1'b0);
    rd(19'h10);
    output_enable_n <= 1'b0;
    #1 chk(dq_oe, 1'b1);
    sleep_request <= 1'b1;
    #1 chk(dq_oe, 1'b0);
    wr(19'h10, 4'h0, 36'h0);
    exp_mem[19'h10] = keep;
    idle();
    sleep_request <= 1'b0;
    rd_chk(19'h10);
    $display("enable and sleep done");
  endtask
  task automatic t_apb();
    logic [31:0] q;
    logic e;
    apb(1'b0, late_write_burst_sram_port_pkg::CFG_OFF, '0, q, e);
    chk(q, late_write_burst_sram_port_pkg::CFG_RESET);
    // Pipeline drained and burst idle after the trailing deselects
    apb(1'b0, late_write_burst_sram_port_pkg::STATUS_OFF, '0, q, e);
    chk({q, e}, 33'h0);
    apb(1'b0, 8'h08, '0, q, e);
    chk({q, e}, 33'h1);
    apb(1'b1, 8'h08, 32'h1, q, e);
    chk(e, 1'b1);
    apb(1'b1, late_write_burst_sram_port_pkg::CFG_OFF, '0, q, e);
    par_on = 1'b0;
    wr(19'h20, 4'h0, 36'hf1234abcd);
    rd_chk(19'h20);
    apb(1'b1, late_write_burst_sram_port_pkg::CFG_OFF, 32'h1, q, e);
    par_on = 1'b1;
    $display("register access done");
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_basic();
    t_fwd();
    t_desel();
    t_burst(1'b1);
    t_burst(1'b0);
    t_hold();
    t_oe_sleep();
    t_apb();
    test_done();
  end
  // Watchdog well beyond the hundred or so cycles the tests need
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    test_done();
  end
endmodule
